// ===== inc/tscr_pkg.sv
// Shared constants for the text spacing and colour register block.
// Assumes an APB slave with 32-bit data and one register per word.

package tscr_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_LINE_GAP    = 8'hD0; // text_line_gap
  localparam logic [7:0] IDX_GLYPH_SPACE = 8'hD1; // glyph_spacing
  localparam logic [7:0] IDX_FORE_RED    = 8'hD2; // fore_color_red
  localparam logic [7:0] IDX_FORE_GREEN  = 8'hD3; // fore_color_green
  localparam logic [7:0] IDX_FORE_BLUE   = 8'hD4; // fore_color_blue
  localparam logic [7:0] IDX_BACK_RED    = 8'hD5; // back_color_red
  localparam logic [7:0] IDX_BACK_GREEN  = 8'hD6; // back_color_green
  localparam logic [7:0] IDX_CURSOR_X    = 8'hF0; // Text cursor column, RO
  localparam logic [7:0] IDX_CURSOR_Y    = 8'hF1; // Text cursor row, RO

  // ---------------------------------------------------------------
  // Field widths and reset values
  // ---------------------------------------------------------------
  localparam int         LGAP_W     = 5;     // Line gap field, bits 4..0
  localparam int         SPACE_W    = 6;     // Spacing field, bits 5..0
  localparam logic [7:0] RST_FORE   = 8'hFF; // Foreground channels
  localparam logic [7:0] RST_BACK   = 8'h00; // Background channels
  localparam logic [7:0] RST_SPACING = 8'h00; // Gap and spacing

  // ---------------------------------------------------------------
  // Colour depth codes and per-channel masks
  // ---------------------------------------------------------------
  localparam logic [1:0] DEPTH_256 = 2'h0; // 256 colours
  localparam logic [1:0] DEPTH_65K = 2'h1; // 65K colours
  localparam logic [1:0] DEPTH_16M = 2'h2; // 16.7M colours
  localparam logic [7:0] MASK_R256 = 8'hE0; // Red bits 7..5
  localparam logic [7:0] MASK_R65K = 8'hF8; // Red bits 7..3
  localparam logic [7:0] MASK_G256 = 8'hE0; // Green bits 7..5
  localparam logic [7:0] MASK_G65K = 8'hFC; // Green bits 7..2
  localparam logic [7:0] MASK_B256 = 8'hC0; // Blue bits 7..6
  localparam logic [7:0] MASK_B65K = 8'hF8; // Blue bits 7..3
  localparam logic [7:0] MASK_FULL = 8'hFF; // All bits

  // Placement engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_PLACE = 2'b10
  } tscr_state_e;

endpackage

// ===== verilog/tscr_color_fmt.sv
// Colour formatter: masks one RGB triple to the active colour depth.
// Assumes depth is a static mode setting driven from the same clock.

`timescale 1ns/1ns

module tscr_color_fmt
  import tscr_pkg::*;
(
  input  wire logic       mclk,    // System clock
  input  wire logic       reset_n, // Async reset, active low
  input  wire logic [1:0] depth,   // Colour depth code
  input  wire logic [7:0] red,     // Raw red channel
  input  wire logic [7:0] green,   // Raw green channel
  input  wire logic [7:0] blue,    // Raw blue channel
  output logic      [7:0] red_q,   // Masked red
  output logic      [7:0] green_q, // Masked green
  output logic      [7:0] blue_q   // Masked blue
);

  // ---------------------------------------------------------------
  // Mask selection
  // ---------------------------------------------------------------
  // Unknown depth codes fall back to full width rather than black
  function automatic logic [7:0] depth_mask(input logic [1:0] d,
                                            input logic [7:0] m256,
                                            input logic [7:0] m65k);
    case (d)
      DEPTH_256: depth_mask = m256;
      DEPTH_65K: depth_mask = m65k;
      default:   depth_mask = MASK_FULL;
    endcase
  endfunction

  wire logic [7:0] red_d   = red   & depth_mask(depth, MASK_R256, MASK_R65K);
  wire logic [7:0] green_d = green & depth_mask(depth, MASK_G256, MASK_G65K);
  wire logic [7:0] blue_d  = blue  & depth_mask(depth, MASK_B256, MASK_B65K);

  // Output registers; colours come straight out of flip-flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      red_q   <= 8'h00;
      green_q <= 8'h00;
      blue_q  <= 8'h00;
    end else begin
      red_q   <= red_d;
      green_q <= green_d;
      blue_q  <= blue_d;
    end
  end

endmodule

// ===== verilog/tscr_regs.sv
// Text spacing and colour registers with text placement engine.
// Assumes an APB master on mclk and a text engine that requests one
// glyph placement at a time through the glyph handshake.

`timescale 1ns/1ns

module tscr_regs
  import tscr_pkg::*;
#(
  parameter int COORD_W = 11  // Pixel coordinate width
)(
  input  wire logic               mclk,          // System clock
  input  wire logic               reset_n,       // Async reset
  input  wire logic               psel,          // APB select
  input  wire logic               penable,       // APB enable
  input  wire logic               pwrite,        // APB direction
  input  wire logic [11:0]        paddr,         // APB byte address
  input  wire logic [31:0]        pwdata,        // APB write data
  input  wire logic [3:0]         pstrb,         // APB byte strobes
  output logic                    pready,        // APB ready
  output logic                    pslverr,       // APB error
  output logic      [31:0]        prdata,        // APB read data
  input  wire logic [1:0]         color_depth,   // Colour depth code
  input  wire logic [7:0]         back_blue,     // Background blue
  input  wire logic [COORD_W-1:0] win_left,      // Window left column
  input  wire logic [COORD_W-1:0] win_right,     // Window right column
  input  wire logic [COORD_W-1:0] win_top,       // Window top row
  input  wire logic               text_home,     // Cursor to origin
  input  wire logic               glyph_valid,   // Glyph request
  output logic                    glyph_ready,   // Engine can take
  input  wire logic [5:0]         glyph_w,       // Glyph width, px
  input  wire logic [5:0]         glyph_h,       // Glyph height, px
  input  wire logic [1:0]         enlarge_w,     // Width factor - 1
  input  wire logic [1:0]         enlarge_h,     // Height factor - 1
  output logic                    place_valid,   // Placement pulse
  output logic      [COORD_W-1:0] place_x,       // Glyph column
  output logic      [COORD_W-1:0] place_y,       // Glyph row
  output logic                    place_wrapped, // Line was wrapped
  output logic      [LGAP_W-1:0]  gap_rows,      // Rows between lines
  output logic      [SPACE_W-1:0] space_cols,    // Cols between glyphs
  output logic      [7:0]         fore_r,        // Foreground red
  output logic      [7:0]         fore_g,        // Foreground green
  output logic      [7:0]         fore_b,        // Foreground blue
  output logic      [7:0]         back_r,        // Gap/space fill red
  output logic      [7:0]         back_g,        // Gap/space fill green
  output logic      [7:0]         back_b         // Gap/space fill blue
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  // Glyph size times its enlargement factor
  function automatic logic [COORD_W:0] scaled(input logic [5:0] size,
                                              input logic [1:0] fac);
    scaled = (COORD_W+1)'({2'b00, size} * ({6'h00, fac} + 8'h01));
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [LGAP_W-1:0]  line_gap_q;    // Blank rows between lines
  logic [SPACE_W-1:0] glyph_space_q; // Blank columns between glyphs
  logic [7:0]         fore_red_q;    // Foreground red
  logic [7:0]         fore_green_q;  // Foreground green
  logic [7:0]         fore_blue_q;   // Foreground blue
  logic [7:0]         back_red_q;    // Background red
  logic [7:0]         back_green_q;  // Background green
  logic [31:0]        prdata_q;      // Read data register
  logic [COORD_W-1:0] cur_x_q;       // Cursor column
  logic [COORD_W-1:0] cur_y_q;       // Cursor row
  logic [COORD_W:0]   wpx_q;         // Enlarged glyph width
  logic [COORD_W:0]   hpx_q;         // Enlarged glyph height
  logic [COORD_W-1:0] place_x_q;     // Placement column
  logic [COORD_W-1:0] place_y_q;     // Placement row
  logic               place_valid_q; // Placement pulse
  logic               wrapped_q;     // Last placement wrapped
  tscr_state_e        state_q;       // Engine state
  tscr_state_e        state_d;       // Next engine state

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic setup_ph  = psel && !penable;
  wire logic access_ph = psel && penable;
  wire logic hit_gap   = (paddr == reg_addr(IDX_LINE_GAP));
  wire logic hit_space = (paddr == reg_addr(IDX_GLYPH_SPACE));
  wire logic hit_fr    = (paddr == reg_addr(IDX_FORE_RED));
  wire logic hit_fg    = (paddr == reg_addr(IDX_FORE_GREEN));
  wire logic hit_fb    = (paddr == reg_addr(IDX_FORE_BLUE));
  wire logic hit_br    = (paddr == reg_addr(IDX_BACK_RED));
  wire logic hit_bg    = (paddr == reg_addr(IDX_BACK_GREEN));
  wire logic hit_cx    = (paddr == reg_addr(IDX_CURSOR_X));
  wire logic hit_cy    = (paddr == reg_addr(IDX_CURSOR_Y));
  wire logic hit_rw    = hit_gap | hit_space | hit_fr | hit_fg
                       | hit_fb | hit_br | hit_bg;
  wire logic hit_any   = hit_rw | hit_cx | hit_cy;
  // Full 12-bit compare: aliases of a register answer as unmapped
  // Writes land only with the low byte lane enabled
  wire logic wr_en     = access_ph && pwrite && pstrb[0] && hit_rw;
  wire logic [7:0] wb  = pwdata[7:0];

  // Read mux; unused upper bits are zero-extended
  wire logic [31:0] rd_word =
      hit_gap   ? {27'h0, line_gap_q}    :
      hit_space ? {26'h0, glyph_space_q} :
      hit_fr    ? {24'h0, fore_red_q}    :
      hit_fg    ? {24'h0, fore_green_q}  :
      hit_fb    ? {24'h0, fore_blue_q}   :
      hit_br    ? {24'h0, back_red_q}    :
      hit_bg    ? {24'h0, back_green_q}  :
      hit_cx    ? {{(32-COORD_W){1'b0}}, cur_x_q} :
      hit_cy    ? {{(32-COORD_W){1'b0}}, cur_y_q} :
                  32'h0;

  // Zero wait states: read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph && !hit_any;
  assign prdata  = prdata_q;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Cursor words are read only; writes to them are dropped silently
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      line_gap_q    <= RST_SPACING[LGAP_W-1:0];
      glyph_space_q <= RST_SPACING[SPACE_W-1:0];
      fore_red_q    <= RST_FORE;
      fore_green_q  <= RST_FORE;
      fore_blue_q   <= RST_FORE;
      back_red_q    <= RST_BACK;
      back_green_q  <= RST_BACK;
    end else if (wr_en) begin
      if (hit_gap)   line_gap_q    <= wb[LGAP_W-1:0];
      if (hit_space) glyph_space_q <= wb[SPACE_W-1:0];
      if (hit_fr)    fore_red_q    <= wb;
      if (hit_fg)    fore_green_q  <= wb;
      if (hit_fb)    fore_blue_q   <= wb;
      if (hit_br)    back_red_q    <= wb;
      if (hit_bg)    back_green_q  <= wb;
    end
  end

  // Read data register, loaded once per read in its setup cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) prdata_q <= 32'h0;
    else if (setup_ph && !pwrite) prdata_q <= rd_word;
  end

  // ---------------------------------------------------------------
  // Colour formatting per depth
  // ---------------------------------------------------------------
  // Foreground feeds draw, text and expansion alike
  tscr_color_fmt u_fore (
    .mclk    (mclk),
    .reset_n (reset_n),
    .depth   (color_depth),
    .red     (fore_red_q),
    .green   (fore_green_q),
    .blue    (fore_blue_q),
    .red_q   (fore_r),
    .green_q (fore_g),
    .blue_q  (fore_b)
  );

  // Background feeds text, expansion and the gap/space fill
  tscr_color_fmt u_back (
    .mclk    (mclk),
    .reset_n (reset_n),
    .depth   (color_depth),
    .red     (back_red_q),
    .green   (back_green_q),
    .blue    (back_blue),
    .red_q   (back_r),
    .green_q (back_g),
    .blue_q  (back_b)
  );

  // Fill geometry handed to the pixel writer, never scaled
  assign gap_rows   = line_gap_q;
  assign space_cols = glyph_space_q;

  // ---------------------------------------------------------------
  // Placement engine
  // ---------------------------------------------------------------
  // Wrap when the enlarged glyph would pass the right window edge
  wire logic [COORD_W:0] reach  = {1'b0, cur_x_q} + wpx_q;
  wire logic [COORD_W:0] limit  = {1'b0, win_right} + 1'b1;
  wire logic             wrap   = (reach > limit);
  // Next row adds the unenlarged gap to the enlarged glyph height
  wire logic [COORD_W:0] next_y = {1'b0, cur_y_q} + hpx_q
                                + {{(COORD_W+1-LGAP_W){1'b0}}, line_gap_q};
  wire logic [COORD_W-1:0] px   = wrap ? win_left : cur_x_q;
  wire logic [COORD_W-1:0] py   = wrap ? next_y[COORD_W-1:0] : cur_y_q;
  // Spacing is added after the glyph, again not enlarged
  wire logic [COORD_W:0] next_x = {1'b0, px} + wpx_q
                                + {{(COORD_W+1-SPACE_W){1'b0}}, glyph_space_q};

  assign glyph_ready   = (state_q == ST_IDLE) && !text_home;
  assign place_valid   = place_valid_q;
  assign place_x       = place_x_q;
  assign place_y       = place_y_q;
  assign place_wrapped = wrapped_q;

  // Next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (glyph_valid && glyph_ready) state_d = ST_PLACE;
      ST_PLACE: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // State register and glyph size capture
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      wpx_q   <= '0;
      hpx_q   <= '0;
    end else begin
      state_q <= state_d;
      if (glyph_valid && glyph_ready) begin
        wpx_q <= scaled(glyph_w, enlarge_w);
        hpx_q <= scaled(glyph_h, enlarge_h);
      end
    end
  end

  // Cursor and placement results; home wins only while idle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_x_q       <= '0;
      cur_y_q       <= '0;
      place_x_q     <= '0;
      place_y_q     <= '0;
      place_valid_q <= 1'b0;
      wrapped_q     <= 1'b0;
    end else begin
      place_valid_q <= (state_q == ST_PLACE);
      if (state_q == ST_PLACE) begin
        place_x_q <= px;
        place_y_q <= py;
        wrapped_q <= wrap;
        cur_x_q   <= next_x[COORD_W-1:0];
        cur_y_q   <= py;
      end else if (text_home) begin
        cur_x_q <= win_left;
        cur_y_q <= win_top;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_wrap_origin: assert property (
    state_q == ST_PLACE && wrap |=> place_valid && place_x == win_left
      && wrapped_q)
    else $error("wrapped glyph not at window left");

  a_gap_row: assert property (
    state_q == ST_PLACE && wrap
      |=> place_y == $past(next_y[COORD_W-1:0]))
    else $error("wrapped row misses line gap");

  a_no_wrap_row: assert property (
    state_q == ST_PLACE && !wrap |=> place_y == $past(cur_y_q))
    else $error("row moved without wrap");

  a_space_step: assert property (
    place_valid |-> cur_x_q == COORD_W'(place_x + wpx_q
      + {{(COORD_W+1-SPACE_W){1'b0}}, glyph_space_q}))
    else $error("cursor step ignores spacing");

  // Spacing reaches the fill path as written while glyphs are enlarged
  a_fill_unscaled: assert property (
    wr_en && hit_space && enlarge_w != 2'h0
      |=> space_cols == SPACE_W'($past(wb)))
    else $error("spacing width altered");

  // Colour outputs are registered, so each mask check waits for a depth
  // that has held for two edges
  a_red_depth: assert property (
    (color_depth == DEPTH_256) [*2] |-> fore_r[4:0] == 5'h0
      && back_r[4:0] == 5'h0)
    else $error("red low bits leak at 256 colours");

  a_green_depth: assert property (
    (color_depth == DEPTH_65K) [*2] |-> fore_g[1:0] == 2'h0
      && back_g[1:0] == 2'h0)
    else $error("green low bits leak at 65K colours");

  a_blue_depth: assert property (
    color_depth == DEPTH_256 ##1 color_depth == DEPTH_256
      && $stable(fore_blue_q) |-> fore_b == (fore_blue_q & MASK_B256))
    else $error("blue mask wrong at 256 colours");

  a_fore_reset: assert property (
    $rose(reset_n) |-> fore_red_q == RST_FORE
      && fore_blue_q == RST_FORE)
    else $error("foreground not all ones after reset");

  a_back_reset: assert property (
    $rose(reset_n) |-> back_red_q == RST_BACK
      && back_green_q == RST_BACK)
    else $error("background not zero after reset");

  a_gap_readback: assert property (
    access_ph && !pwrite && hit_gap |-> prdata[31:LGAP_W] == '0)
    else $error("line gap upper bits not zero");

  a_write_back: assert property (
    wr_en && hit_fr |=> fore_red_q == $past(wb))
    else $error("foreground red write lost");

  // Main scenarios: wrap, back-to-back glyphs, bad address, writes
  c_wrap_seen: cover property (place_valid && place_wrapped);
  c_two_glyphs: cover property (place_valid ##[1:8] place_valid);
  c_bad_addr: cover property (access_ph && pslverr);
  c_space_write: cover property (wr_en && hit_space);

endmodule

// ===== verif/tscr_regs_tb.sv
// Self-checking bench for the text spacing and colour register block.
// Assumes tscr_pkg is compiled first; the bench acts as APB master and
// as the text engine that requests glyph placements.

`timescale 1ns/1ns

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tscr_regs_tb
  import tscr_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        mclk;          // System clock
  logic        reset_n;       // Async reset, active low
  logic        psel;          // APB select
  logic        penable;       // APB enable
  logic        pwrite;        // APB direction
  logic [11:0] paddr;         // APB byte address
  logic [31:0] pwdata;        // APB write data
  logic [3:0]  pstrb;         // APB strobes
  logic        pready;        // APB ready
  logic        pslverr;       // APB error
  logic [31:0] prdata;        // APB read data
  logic [1:0]  color_depth;   // Colour depth code
  logic [7:0]  back_blue;     // Background blue
  logic [10:0] win_left;      // Window bounds
  logic [10:0] win_right;
  logic [10:0] win_top;
  logic        text_home;     // Cursor home pulse
  logic        glyph_valid;   // Glyph request
  logic        glyph_ready;   // Engine idle
  logic [5:0]  glyph_w;       // Glyph size
  logic [5:0]  glyph_h;
  logic [1:0]  enlarge_w;     // Enlargement factors minus one
  logic [1:0]  enlarge_h;
  logic        place_valid;   // Placement pulse
  logic [10:0] place_x;       // Placement position
  logic [10:0] place_y;
  logic        place_wrapped; // Placement wrapped
  logic [4:0]  gap_rows;      // Line gap out
  logic [5:0]  space_cols;    // Glyph spacing out
  logic [7:0]  fore_r, fore_g, fore_b, back_r, back_g, back_b;
  int          n_errors = 0;  // Mismatch count
  int          compares = 0;  // Comparison count

  tscr_regs dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .color_depth(color_depth), .back_blue(back_blue),
    .win_left(win_left), .win_right(win_right), .win_top(win_top),
    .text_home(text_home), .glyph_valid(glyph_valid),
    .glyph_ready(glyph_ready), .glyph_w(glyph_w), .glyph_h(glyph_h),
    .enlarge_w(enlarge_w), .enlarge_h(enlarge_h),
    .place_valid(place_valid), .place_x(place_x), .place_y(place_y),
    .place_wrapped(place_wrapped), .gap_rows(gap_rows),
    .space_cols(space_cols), .fore_r(fore_r), .fore_g(fore_g),
    .fore_b(fore_b), .back_r(back_r), .back_g(back_g), .back_b(back_b)
  );

  // ---------------------------------------------------------------
  // Clock, verdict and helpers
  // ---------------------------------------------------------------
  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Single exit point for pass, fail and timeouts
  task automatic conclude;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Kept bits per depth; written from the channel tables, not the package
  function automatic logic [7:0] msk(input int d, input int ch,
                                     input logic [7:0] v);
    logic [7:0] m[3][3] = '{'{8'hE0, 8'hF8, 8'hFF},  // Red
                            '{8'hE0, 8'hFC, 8'hFF},  // Green
                            '{8'hC0, 8'hF8, 8'hFF}}; // Blue
    return v & m[ch][(d > 2) ? 2 : d];
  endfunction

  // One APB transfer; an idle edge follows so psel is never set twice
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Register write, byte in bits 7..0
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic        er;
    xfer(1'b1, a, {24'h0, v}, d, er);
  endtask

  // Register read compared with an expected byte and no error
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic        er;
    xfer(1'b0, a, 32'h0, d, er);
    `CHK("prdata", {24'h0, e}, d)
    `CHK("pslverr", 1'b0, er)
  endtask

  // Let registered outputs land, then look between edges
  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  // One glyph request; waits for take, then for the placement pulse
  task automatic glyph(input logic [10:0] ex, input logic [10:0] ey,
                       input logic ew);
    int n;
    glyph_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (glyph_ready !== 1'b1 && n < 50);
    if (glyph_ready !== 1'b1) begin
      n_errors++;
      conclude();
    end
    glyph_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (place_valid !== 1'b1 && n < 6);
    `CHK("place_valid", 1'b1, place_valid)
    `CHK("place latency", 2, n)
    `CHK("place_x", ex, place_x)
    `CHK("place_y", ey, place_y)
    `CHK("place_wrapped", ew, place_wrapped)
    if (place_valid !== 1'b1) conclude();
    @(posedge mclk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [7:0]  vals[7] = '{8'hFF, 8'hFF, 8'hB7, 8'h6D, 8'h5B, 8'h93,
                             8'h2E};
    logic [7:0]  rst[7]  = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00,
                             8'h00};
    logic [31:0] d;
    logic        er;
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF; color_depth = 2'h2;
    back_blue = 8'h5A; win_left = 11'h0; win_right = 11'h063;
    win_top = 11'h0; text_home = 1'b0; glyph_valid = 1'b0;
    glyph_w = 6'h08; glyph_h = 6'h10; enlarge_w = 2'h1; enlarge_h = 2'h1;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    // Reset values of every read/write register
    for (int i = 0; i < 7; i++) begin
      rd_chk(12'h340 + 12'(4 * i), rst[i]);
    end
    // Readback, unused upper bits read zero
    for (int i = 0; i < 7; i++) begin
      wr(12'h340 + 12'(4 * i), vals[i]);
    end
    rd_chk(12'h340, 8'h1F);
    rd_chk(12'h344, 8'h3F);
    for (int i = 2; i < 7; i++) begin
      rd_chk(12'h340 + 12'(4 * i), vals[i]);
    end
    settle();
    `CHK("gap_rows", 5'h1F, gap_rows)
    `CHK("space_cols", 6'h3F, space_cols)
    // Unmapped word answers with an error and zero
    @(posedge mclk);
    xfer(1'b0, 12'h000, 32'h0, d, er);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, d)
    // Channel masks at every depth code; code 3 keeps all bits
    for (int dp = 0; dp < 4; dp++) begin
      color_depth <= 2'(dp);
      settle();
      `CHK("fore_r", msk(dp, 0, 8'hB7), fore_r)
      `CHK("fore_g", msk(dp, 1, 8'h6D), fore_g)
      `CHK("fore_b", msk(dp, 2, 8'h5B), fore_b)
      `CHK("back_r", msk(dp, 0, 8'h93), back_r)
      `CHK("back_g", msk(dp, 1, 8'h2E), back_g)
      `CHK("back_b", msk(dp, 2, 8'h5A), back_b)
      @(posedge mclk);
    end
    // Placement: step 16 + 3, wrap on the sixth glyph, gap not enlarged
    wr(12'h340, 8'h05);
    wr(12'h344, 8'h03);
    text_home <= 1'b1;
    @(posedge mclk);
    text_home <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      glyph(11'((i < 5) ? 19 * i : 19 * (i - 5)), 11'((i < 5) ? 0 : 37),
            i == 5);
    end
    // Cursor words: last glyph at 19, so cursor at 19 + 16 + 3, row 37
    rd_chk(12'h3C0, 8'h26);
    rd_chk(12'h3C4, 8'h25);
    wr(12'h3C0, 8'h00);
    rd_chk(12'h3C0, 8'h26);
    // A write without the low byte lane is dropped
    pstrb <= 4'h0;
    wr(12'h348, 8'h00);
    pstrb <= 4'hF;
    rd_chk(12'h348, 8'hB7);
    // Reset in mid-run brings back the defaults
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd_chk(12'h348, 8'hFF);
    rd_chk(12'h358, 8'h00);
    conclude();
  end
endmodule
